// File: spi_flag_pkg.sv
// Shared constants and types of the serial status-flag block
package spi_flag_pkg;
    // Register indexes on the byte-wide port
    localparam logic [1:0] CTRL_ADDR = 2'h0;
    localparam logic [1:0] STAT_ADDR = 2'h1;
    localparam logic [1:0] DATA_ADDR = 2'h2;
    // Control register bit positions
    localparam int IRQ_EN_BIT = 7;
    localparam int OUT_EN_BIT = 6;
    localparam int MASTER_BIT = 4;
    // Status register bit positions
    localparam int DONE_BIT   = 7;
    localparam int WRITE_COLLISION_FLAG_BIT   = 6;
    localparam int OVR_BIT    = 5;
    localparam int MODE_FAULT_FLAG_BIT   = 4;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // Index of the last bit in one serial frame
    localparam logic [2:0] LAST_BIT = 3'h7;

    // One register-port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } bus_req_t;
endpackage

// File: spi_flag_ctrl.sv
// Status flags, control register and link shifter of the serial port
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module spi_flag_ctrl (
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    input  wire spi_flag_pkg::bus_req_t  BUS_REQ,
    output logic [7:0]                   RDATA,
    input  wire logic                    SCK,
    input  wire logic                    MOSI_I,
    output logic                         MISO_O,
    output logic                         MISO_OE,
    input  wire logic                    SS_N_I,
    output logic                         IRQ
);
    // Control and data storage
    logic [7:0] ctrl_q;       // Control register
    logic [7:0] tx_q;         // Byte to send
    logic [7:0] rx_q;         // Last received byte
    // Flags
    logic       done_q;       // Transfer done
    logic       write_collision_flag_q;       // Write collision
    logic       ovr_q;        // Overrun
    logic       mode_fault_flag_q;       // Mode fault
    logic [2:0] low_q;        // Low status bits, plain storage
    // Clear-sequence arming
    logic       arm_done_q;   // Status seen with done set
    logic       arm_write_collision_flag_q;   // Status read with collision set
    logic       arm_mode_fault_flag_q;   // Control accessed with fault set
    logic       busy_q;       // Transfer in progress
    logic       irq_q;        // Request output
    logic [7:0] rdata_q;      // Read answer
    // Synchronisers
    logic [2:0] tgl_s_q;      // Done toggle from link
    logic [2:0] act_s_q;      // Link activity level
    logic [1:0] ss_s_q;       // Select pin
    // Link domain
    logic [2:0] cnt_q;        // Bit counter
    logic [7:0] sh_q;         // Shift register
    logic [7:0] hold_q;       // Captured byte
    logic       tgl_q;        // Flips at each byte end
    logic       act_q;        // Frame in progress
    logic       miso_q;       // Output bit

    // Decoded strobes
    logic stat_acc;
    logic stat_rd;
    logic ctrl_acc;
    logic ctrl_wr;
    logic data_rd;
    logic data_wr;
    logic wr_ok;
    logic byte_end;
    logic act_rise;
    logic fault;

    // Hit test used by every strobe decode
    function automatic logic hit(input logic [1:0] a);
        hit = (BUS_REQ.addr == a);
    endfunction

    // Strobe decode
    always_comb begin
        stat_acc = (BUS_REQ.rd | BUS_REQ.wr) & hit(spi_flag_pkg::STAT_ADDR);
        stat_rd  = BUS_REQ.rd & hit(spi_flag_pkg::STAT_ADDR);
        ctrl_acc = (BUS_REQ.rd | BUS_REQ.wr) & hit(spi_flag_pkg::CTRL_ADDR);
        ctrl_wr  = BUS_REQ.wr & hit(spi_flag_pkg::CTRL_ADDR);
        data_rd  = BUS_REQ.rd & hit(spi_flag_pkg::DATA_ADDR);
        data_wr  = BUS_REQ.wr & hit(spi_flag_pkg::DATA_ADDR);
        // Blocked while done is set and status not yet seen
        wr_ok    = data_wr & ~(done_q & ~arm_done_q) & ~busy_q;
        byte_end = tgl_s_q[1] ^ tgl_s_q[2];
        act_rise = act_s_q[1] & ~act_s_q[2];
        fault    = ~ss_s_q[1] & ctrl_q[spi_flag_pkg::MASTER_BIT];
    end

    // Two-flop pin and three-flop cross-domain capture; stage 0 feeds stage 1 only
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tgl_s_q <= 3'h0;
            act_s_q <= 3'h0;
            ss_s_q  <= 2'h3;
        end else begin
            tgl_s_q <= {tgl_s_q[1:0], tgl_q};
            act_s_q <= {act_s_q[1:0], act_q};
            ss_s_q  <= {ss_s_q[0], SS_N_I};
        end
    end

    // Control register; hardware fault wins over software
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= spi_flag_pkg::CTRL_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= BUS_REQ.wdata;
            end
            if (fault) begin
                ctrl_q[spi_flag_pkg::OUT_EN_BIT] <= 1'b0;
                ctrl_q[spi_flag_pkg::MASTER_BIT] <= 1'b0;
            end
        end
    end

    // Low status bits; bit three always reads zero
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            low_q <= spi_flag_pkg::STAT_RST[2:0];
        end else if (BUS_REQ.wr && hit(spi_flag_pkg::STAT_ADDR)) begin
            low_q <= BUS_REQ.wdata[2:0];
        end
    end

    // Transmit byte; a colliding write leaves it untouched
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_q <= spi_flag_pkg::DATA_RST;
        end else if (wr_ok) begin
            tx_q <= BUS_REQ.wdata;
        end
    end

    // Received byte taken once the link byte is stable
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_q <= spi_flag_pkg::DATA_RST;
        end else if (byte_end) begin
            rx_q <= hold_q;
        end
    end

    // Busy from accepted write or frame start until byte end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_q <= 1'b0;
        end else if (byte_end) begin
            busy_q <= 1'b0;
        end else if (wr_ok || act_rise) begin
            busy_q <= 1'b1;
        end
    end

    // Done flag; a new byte end beats the clearing access
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            done_q     <= 1'b0;
            arm_done_q <= 1'b0;
        end else begin
            if (byte_end) begin
                done_q     <= 1'b1;
                arm_done_q <= 1'b0;
            end else if (arm_done_q && (data_rd || data_wr)) begin
                done_q     <= 1'b0;
                arm_done_q <= 1'b0;
            end else if (stat_acc && done_q) begin
                arm_done_q <= 1'b1;
            end
        end
    end

    // Collision flag
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            write_collision_flag_q     <= 1'b0;
            arm_write_collision_flag_q <= 1'b0;
        end else begin
            if (data_wr && busy_q) begin
                write_collision_flag_q     <= 1'b1;
                arm_write_collision_flag_q <= 1'b0;
            end else if (arm_write_collision_flag_q && data_rd) begin
                write_collision_flag_q     <= 1'b0;
                arm_write_collision_flag_q <= 1'b0;
            end else if (stat_rd && write_collision_flag_q) begin
                arm_write_collision_flag_q <= 1'b1;
            end
        end
    end

    // Overrun flag; set wins over the status read
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovr_q <= 1'b0;
        end else if (byte_end && done_q) begin
            ovr_q <= 1'b1;
        end else if (stat_rd) begin
            ovr_q <= 1'b0;
        end
    end

    // Mode fault flag
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_fault_flag_q     <= 1'b0;
            arm_mode_fault_flag_q <= 1'b0;
        end else begin
            if (fault) begin
                mode_fault_flag_q <= 1'b1;
            end else if (arm_mode_fault_flag_q && ctrl_wr) begin
                mode_fault_flag_q <= 1'b0;
            end
            if (arm_mode_fault_flag_q && ctrl_wr) begin
                arm_mode_fault_flag_q <= 1'b0;
            end else if (ctrl_acc && mode_fault_flag_q) begin
                arm_mode_fault_flag_q <= 1'b1;
            end
        end
    end

    // Shared request of done, overrun and mode fault; enable low masks all three
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ctrl_q[spi_flag_pkg::IRQ_EN_BIT]
                   & (done_q | ovr_q | mode_fault_flag_q);
        end
    end

    // Read answer, one cycle after the strobe
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
        end else if (BUS_REQ.rd) begin
            unique case (BUS_REQ.addr)
                spi_flag_pkg::CTRL_ADDR: rdata_q <= ctrl_q;
                // Done hidden while a byte is on the wire
                spi_flag_pkg::STAT_ADDR: rdata_q <= {done_q & ~busy_q,
                    write_collision_flag_q, ovr_q, mode_fault_flag_q, 1'b0, low_q};
                spi_flag_pkg::DATA_ADDR: rdata_q <= rx_q;
                default:                 rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // Link shifter: clocked by every rising SCK edge whatever the select pin, so idle edges
    // would be counted on too; the toggle marks a finished byte.
    always_ff @(posedge SCK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q  <= 3'h0;
            sh_q   <= 8'h00;
            hold_q <= 8'h00;
            tgl_q  <= 1'b0;
            act_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == spi_flag_pkg::LAST_BIT) begin
                hold_q <= {sh_q[6:0], MOSI_I};
                tgl_q  <= ~tgl_q;
                act_q  <= 1'b0;
            end else begin
                act_q <= 1'b1;
            end
            sh_q <= {sh_q[6:0], MOSI_I};
        end
    end

    // Output bit launched on the rising edge and taken by the far master
    // on the falling edge, so the first bit needs no preload before the
    // frame; tx byte is stable while busy
    always_ff @(posedge SCK or negedge RST_N) begin
        if (!RST_N) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= tx_q[spi_flag_pkg::LAST_BIT - cnt_q];
        end
    end

    assign RDATA   = rdata_q;
    assign IRQ     = irq_q;
    assign MISO_O  = miso_q;
    assign MISO_OE = ctrl_q[spi_flag_pkg::OUT_EN_BIT];

    // Checks, CPU domain
    property p_done_set;
        @(posedge CLK) disable iff (!RST_N) byte_end |=> done_q;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set");
    property p_irq;
        @(posedge CLK) disable iff (!RST_N)
            (ctrl_q[spi_flag_pkg::IRQ_EN_BIT] && (done_q || ovr_q || mode_fault_flag_q)) |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("request missing");
    property p_done_hold;
        @(posedge CLK) disable iff (!RST_N)
            (done_q && !arm_done_q && !byte_end) |=> done_q;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done lost");
    property p_block;
        @(posedge CLK) disable iff (!RST_N)
            (data_wr && done_q && !arm_done_q) |=> $stable(tx_q);
    endproperty
    a_block: assert property (p_block) else $error("write not blocked");
    property p_write_collision_flag;
        @(posedge CLK) disable iff (!RST_N) (data_wr && busy_q) |=> write_collision_flag_q;
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("no collision");
    property p_ovr;
        @(posedge CLK) disable iff (!RST_N) (byte_end && done_q) |=> ovr_q;
    endproperty
    a_ovr: assert property (p_ovr) else $error("no overrun");
    property p_ovr_clr;
        @(posedge CLK) disable iff (!RST_N)
            (stat_rd && !(byte_end && done_q)) |=> !ovr_q;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun kept");
    property p_mode_fault_flag;
        @(posedge CLK) disable iff (!RST_N)
            fault |=> (mode_fault_flag_q && !ctrl_q[spi_flag_pkg::OUT_EN_BIT]
                && !ctrl_q[spi_flag_pkg::MASTER_BIT]);
    endproperty
    a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("fault not handled");
    property p_mask;
        @(posedge CLK) disable iff (!RST_N) !ctrl_q[spi_flag_pkg::IRQ_EN_BIT] |=> !IRQ;
    endproperty
    a_mask: assert property (p_mask) else $error("request not masked");
    property p_write_collision_flag_clr;
        @(posedge CLK) disable iff (!RST_N)
            (arm_write_collision_flag_q && data_rd && !(data_wr && busy_q)) |=> !write_collision_flag_q;
    endproperty
    a_write_collision_flag_clr: assert property (p_write_collision_flag_clr) else $error("collision kept");
    property p_mode_fault_flag_clr;
        @(posedge CLK) disable iff (!RST_N)
            (arm_mode_fault_flag_q && ctrl_wr && !fault) |=> !mode_fault_flag_q;
    endproperty
    a_mode_fault_flag_clr: assert property (p_mode_fault_flag_clr) else $error("fault kept");
    c_byte:  cover property (@(posedge CLK) disable iff (!RST_N) byte_end);
    c_clear: cover property (@(posedge CLK) disable iff (!RST_N)
        arm_done_q ##1 !done_q);
    c_fault: cover property (@(posedge CLK) disable iff (!RST_N) fault);
endmodule

// File: spi_flag_peer.sv
// Behavioural external serial master driving the link of the flag block
`timescale 1ns/100ps
module spi_flag_peer (
    output logic      sck,
    output logic      mosi,
    output logic      ss_n,
    input  wire logic miso,
    input  wire logic miso_oe
);
    logic [7:0] rx_byte;    // Bits collected from the slave output

    // Idle state: clock still, select high
    initial begin
        sck = 1'b0;
        mosi = 1'b1;
        ss_n = 1'b1;
        rx_byte = 8'h00;
    end

    // Select pin alone, used to provoke the master fault
    task automatic select(input logic lvl);
        ss_n = lvl;
    endtask

    // One byte, MSB first, 64 ns link period
    task automatic frame(input logic [7:0] tx);
        ss_n = 1'b0;
        #32;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #32 sck = 1'b1;
            #32 sck = 1'b0;
            // Slave launches on the rising edge; taken here on the falling one
            // Released line would be read as garbage, never as old data
            rx_byte[i] = miso_oe ? miso : ~rx_byte[i];
        end
        // Eighth edge ends the byte; data line stops showing last bit
        mosi = ~mosi;
        #32 ss_n = 1'b1;
    endtask
endmodule

// File: tb_spi_flag_ctrl.sv
// Register-level testbench of the serial status-flag block
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH %0t got %h expected %h", $time, got, exp); end end
module tb_spi_flag_ctrl;
    logic                   CLK;       // System clock
    logic                   RST_N;     // Async reset, active low
    spi_flag_pkg::bus_req_t req;       // Register port request
    logic [7:0]             RDATA;     // Read data
    logic                   SCK;       // Link clock from the peer
    logic                   MOSI_I;    // Serial in
    logic                   MISO_O;    // Serial out
    logic                   MISO_OE;   // Serial out enable
    logic                   SS_N_I;    // Select pin
    logic                   IRQ;       // Request line
    int                     errors;    // Mismatch count
    int                     compares;  // Comparison count

    spi_flag_ctrl u_dut (
        .CLK     (CLK),
        .RST_N   (RST_N),
        .BUS_REQ (req),
        .RDATA   (RDATA),
        .SCK     (SCK),
        .MOSI_I  (MOSI_I),
        .MISO_O  (MISO_O),
        .MISO_OE (MISO_OE),
        .SS_N_I  (SS_N_I),
        .IRQ     (IRQ)
    );

    spi_flag_peer u_peer (
        .sck     (SCK),
        .mosi    (MOSI_I),
        .ss_n    (SS_N_I),
        .miso    (MISO_O),
        .miso_oe (MISO_OE)
    );

    // 100 MHz system clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // Verdict and end of run
    task automatic give_verdict;
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Single-cycle write strobe; an edge passes before the next request
    task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge CLK);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge CLK);
        req <= '0;
    endtask

    // Read strobe; data stands only in the following cycle
    task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge CLK);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge CLK);
        req <= '0;
        #1 d = RDATA;
    endtask

    // Read and compare
    task automatic chk_rd(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bus_rd(a, d);
        `CHK(d, exp)
    endtask

    // Let registered outputs and synchronisers settle
    task automatic settle(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #100000;
        errors++;
        give_verdict();
    end

    // Main sequence
    initial begin
        errors = 0;
        compares = 0;
        req = '0;
        RST_N = 1'b0;
        repeat (6) @(posedge CLK);
        RST_N <= 1'b1;
        chk_rd(spi_flag_pkg::CTRL_ADDR, spi_flag_pkg::CTRL_RST);
        chk_rd(spi_flag_pkg::STAT_ADDR, spi_flag_pkg::STAT_RST);
        chk_rd(spi_flag_pkg::DATA_ADDR, spi_flag_pkg::DATA_RST);
        // Unmapped place ignores writes and reads zero
        bus_wr(2'h3, 8'hff);
        chk_rd(2'h3, 8'h00);
        // Low status bits are storage; reserved bit written as zero
        bus_wr(spi_flag_pkg::STAT_ADDR, 8'h07);
        chk_rd(spi_flag_pkg::STAT_ADDR, 8'h07);
        bus_wr(spi_flag_pkg::STAT_ADDR, 8'h00);
        bus_wr(spi_flag_pkg::CTRL_ADDR, 8'hc0);
        chk_rd(spi_flag_pkg::CTRL_ADDR, 8'hc0);
        `CHK(MISO_OE, 1'b1)
        // Transfer with a colliding write in mid-frame
        bus_wr(spi_flag_pkg::DATA_ADDR, 8'ha5);
        fork
            u_peer.frame(8'h3c);
            begin
                settle(10);
                bus_wr(spi_flag_pkg::DATA_ADDR, 8'hff);
                chk_rd(spi_flag_pkg::STAT_ADDR, 8'h40);
            end
        join
        settle(8);
        `CHK(u_peer.rx_byte, 8'ha5)
        `CHK(IRQ, 1'b1)
        chk_rd(spi_flag_pkg::STAT_ADDR, 8'hc0);
        chk_rd(spi_flag_pkg::DATA_ADDR, 8'h3c);
        chk_rd(spi_flag_pkg::STAT_ADDR, 8'h00);
        `CHK(IRQ, 1'b0)
        // Done flag blocks data writes, then a second byte overruns
        bus_wr(spi_flag_pkg::DATA_ADDR, 8'h96);
        u_peer.frame(8'h69);
        settle(8);
        bus_wr(spi_flag_pkg::DATA_ADDR, 8'h11);
        chk_rd(spi_flag_pkg::STAT_ADDR, 8'h80);
        // Done hidden while the overrunning byte is on the wire
        fork
            u_peer.frame(8'h77);
            begin
                settle(12);
                chk_rd(spi_flag_pkg::STAT_ADDR, 8'h00);
            end
        join
        settle(8);
        chk_rd(spi_flag_pkg::STAT_ADDR, 8'ha0);
        `CHK(IRQ, 1'b1)
        chk_rd(spi_flag_pkg::STAT_ADDR, 8'h80);
        // Enable low blocks the request while a flag stands
        bus_wr(spi_flag_pkg::CTRL_ADDR, 8'h40);
        settle(2);
        `CHK(IRQ, 1'b0)
        bus_wr(spi_flag_pkg::CTRL_ADDR, 8'hc0);
        chk_rd(spi_flag_pkg::STAT_ADDR, 8'h80);
        chk_rd(spi_flag_pkg::DATA_ADDR, 8'h77);
        chk_rd(spi_flag_pkg::STAT_ADDR, 8'h00);
        // Select pulled low while master
        bus_wr(spi_flag_pkg::CTRL_ADDR, 8'hd0);
        u_peer.select(1'b0);
        settle(8);
        chk_rd(spi_flag_pkg::STAT_ADDR, 8'h10);
        `CHK(IRQ, 1'b1)
        `CHK(MISO_OE, 1'b0)
        chk_rd(spi_flag_pkg::CTRL_ADDR, 8'h80);
        u_peer.select(1'b1);
        settle(4);
        bus_wr(spi_flag_pkg::CTRL_ADDR, 8'h80);
        chk_rd(spi_flag_pkg::STAT_ADDR, 8'h00);
        give_verdict();
    end
endmodule
